// ===== inc/fps_pkg.sv
package fps_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing.
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 10;       // 100 MHz system clock.
  localparam int unsigned OV_DELAY_NS     = 2500;     // Plateau sampling delay after turn-off.
  localparam int unsigned DEBOUNCE_MS     = 75;       // Auto-recovery fault debounce time.
  localparam int unsigned SOFTSTART_MS    = 4;        // Soft-start ramp time.
  localparam int unsigned NS_PER_MS       = 1000000;  // Unit conversion.
  // A least time rounds up to whole cycles.
  localparam int unsigned OV_DELAY_CYC    = (OV_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEBOUNCE_CYC_DEF = (DEBOUNCE_MS * NS_PER_MS) / CLK_PERIOD_NS;
  localparam int unsigned SS_CYC_DEF      = (SOFTSTART_MS * NS_PER_MS) / CLK_PERIOD_NS;
  localparam int unsigned SS_STEPS        = 256;      // Levels in the current-limit ramp.
  localparam int unsigned SS_STEP_CYC_DEF = SS_CYC_DEF / SS_STEPS;

  // ----------------------------------------------------------------------
  // Fault counting and levels.
  // ----------------------------------------------------------------------
  localparam logic [1:0] OV_FAULT_COUNT   = 2'h3;     // Consecutive over-voltage samples to trip.
  localparam logic [7:0] SS_LEVEL_MAX     = 8'hff;    // Full current-limit threshold.
  localparam logic [3:0] VALLEY_BURST     = 4'h8;     // Valley count held during burst.

  // ----------------------------------------------------------------------
  // Synchronised comparator vector layout.
  // ----------------------------------------------------------------------
  localparam int SYNC_W     = 12;
  localparam int IN_FB_LOW  = 0;   // Feedback level below burst gate threshold.
  localparam int IN_OV      = 1;   // Aux winding over-voltage comparator.
  localparam int IN_PWM     = 2;   // Gate pulse from the PWM core.
  localparam int IN_SUP_ON  = 3;   // Supply at or above turn-on level.
  localparam int IN_LOCKOUT = 4;   // Supply at or below lockout off level.
  localparam int IN_LATCH_H = 5;   // Supply at or above latch-high level.
  localparam int IN_SUP_OV  = 6;   // Supply over-voltage.
  localparam int IN_OVLD    = 7;   // Overload fault condition.
  localparam int IN_OVCUR   = 8;   // Overcurrent fault condition.
  localparam int IN_OVPWR   = 9;   // Overpower fault condition.
  localparam int IN_OPEN    = 10;  // Open-loop fault condition.
  localparam int IN_FLOAT   = 11;  // Floating pin detected.

  // ----------------------------------------------------------------------
  // Register map (byte addresses) and fields.
  // ----------------------------------------------------------------------
  localparam logic [3:0]  REG_CTRL      = 4'h0;
  localparam logic [3:0]  REG_STATUS    = 4'h4;
  localparam logic [3:0]  REG_IRQ_STAT  = 4'h8;
  localparam logic [3:0]  REG_IRQ_MASK  = 4'hc;
  localparam logic        CTRL_RESET    = 1'h1;     // Switching enabled after reset.
  localparam logic [3:0]  IRQ_MASK_RESET = 4'h0;
  localparam int          IRQ_W         = 4;
  localparam int          IRQ_LATCH     = 0;        // Latch-type fault entered.
  localparam int          IRQ_AUTO      = 1;        // Auto-recovery fault entered.
  localparam int          IRQ_BURST     = 2;        // Burst off interval entered.
  localparam int          IRQ_RESTART   = 3;        // Soft-start began.
  localparam int          ST_STATE_LSB  = 0;        // Status: state code, bits 2:0.
  localparam int          ST_GATE       = 3;
  localparam int          ST_HV         = 4;
  localparam int          ST_BURST      = 5;
  localparam int          ST_OVCNT_LSB  = 6;        // Status: over-voltage count, bits 7:6.
  localparam int          ST_LEVEL_LSB  = 8;        // Status: current-limit level, bits 15:8.

  // ----------------------------------------------------------------------
  // Sequencer states, Gray coded along startup, soft-start, run, fault.
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_STARTUP  = 3'h0,
    ST_SOFT     = 3'h1,
    ST_RUN      = 3'h3,
    ST_AUTO_OFF = 3'h2,
    ST_LATCHED  = 3'h6
  } fps_state_t;

endpackage : fps_pkg

// ===== verilog/fps_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for a vector of independent comparator levels.
module fps_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ----------------------------------------------------------------------
  // Synchroniser stages.
  // ----------------------------------------------------------------------
  logic [W-1:0] meta_q;  // First stage, read only by the second stage.

  // Both stages freeze with the clock enable so the whole block stops together.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : fps_sync

// ===== verilog/fps_sequencer.sv
`timescale 1ns/1ps
// Overview of operation
// - Feedback below threshold suppresses all gate pulses.
// - Feedback back above threshold resumes switching.
// - Sample over-voltage a fixed delay after turn-off.
// - Each over-voltage sample increments consecutive counter.
// - Three consecutive over-voltage samples latch the fault.
// - A clean sample clears the counter silently.
// - Latched: charge at lockout, stop at latch-high.
// - Latched state clears only on power-down reset.
// - Debounced overload-type faults trigger auto-recovery.
// - Auto-recovery fault stops switching immediately.
// - Lockout level during auto-recovery restarts startup.
// - Restart resumes if fault gone, else repeats.
// - Supply over-voltage is a latch-type fault.
// - Floating pin triggers auto-recovery without debounce.
// - Each restart ramps current limit in soft-start.
// - Switch only between turn-on and lockout levels.
// - Burst mode fixes valley count at maximum.
module fps_sequencer
  import fps_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYC = DEBOUNCE_CYC_DEF,
  parameter int unsigned SS_STEP_CYC  = SS_STEP_CYC_DEF
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  input  wire logic        FB_BELOW_MIN,
  input  wire logic        OV_CMP,
  input  wire logic        PWM_ON,
  input  wire logic        SUPPLY_ON,
  input  wire logic        SUPPLY_LOCKOUT,
  input  wire logic        SUPPLY_LATCH_HIGH,
  input  wire logic        SUPPLY_OV,
  input  wire logic        OVERLOAD,
  input  wire logic        OVERCURRENT,
  input  wire logic        OVERPOWER,
  input  wire logic        OPEN_LOOP,
  input  wire logic        PIN_FLOAT,
  input  wire logic [3:0]  VALLEY_REQ,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  output logic             GATE_EN,
  output logic             HV_CHARGE_EN,
  output logic      [7:0]  CS_LIMIT_LEVEL,
  output logic      [3:0]  VALLEY_LOCK,
  output logic             IRQ
);

  // ----------------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------------
  // Saturating increment, shared by the long counters.
  function automatic logic [31:0] fps_inc(input logic [31:0] v);
    fps_inc = (v == 32'hffffffff) ? v : v + 32'h1;
  endfunction : fps_inc

  // ----------------------------------------------------------------------
  // Input synchronisation.
  // ----------------------------------------------------------------------
  logic [SYNC_W-1:0] raw;   // Comparator levels as they arrive.
  logic [SYNC_W-1:0] s;     // Comparator levels on the internal clock.

  assign raw = {PIN_FLOAT, OPEN_LOOP, OVERPOWER, OVERCURRENT, OVERLOAD, SUPPLY_OV,
                SUPPLY_LATCH_HIGH, SUPPLY_LOCKOUT, SUPPLY_ON, PWM_ON, OV_CMP, FB_BELOW_MIN};

  // All analog comparators pass through two flops before any use.
  fps_sync #(.W(SYNC_W)) u_sync (
    .clk   (CLK),
    .rst_n (RST_N),
    .ce    (CE),
    .d     (raw),
    .q     (s)
  );

  logic fb_low;     // Burst gate request.
  logic ov;         // Plateau above over-voltage threshold.
  logic lockout;    // Supply down at lockout off level.
  logic auto_cond;  // Any debounced auto-recovery condition.
  assign fb_low    = s[IN_FB_LOW];
  assign ov        = s[IN_OV];
  assign lockout   = s[IN_LOCKOUT];
  assign auto_cond = s[IN_OVLD] | s[IN_OVCUR] | s[IN_OVPWR] | s[IN_OPEN];

  // ----------------------------------------------------------------------
  // State declarations.
  // ----------------------------------------------------------------------
  fps_state_t     state_q, state_d;   // Sequencer state.
  logic           pwm_prev_q;         // Gate pulse one cycle ago.
  logic           smp_busy_q;         // Plateau delay running.
  logic [8:0]     smp_cnt_q;          // Cycles since turn-off.
  logic [1:0]     ov_cnt_q;           // Consecutive over-voltage samples.
  logic [31:0]    deb_cnt_q;          // Cycles the auto condition has held.
  logic [31:0]    ss_tick_q;          // Cycles within one ramp step.
  logic           burst_q;            // Burst off interval active.
  logic           ctrl_en_q;          // Software switching enable.
  logic [IRQ_W-1:0] irq_stat_q;       // Sticky event bits.
  logic [IRQ_W-1:0] irq_mask_q;       // Interrupt enables.
  logic           wait_q;             // Bus wait state flop.

  logic pwm_fall;     // Gate turn-off seen.
  logic smp_now;      // Plateau sample strobe.
  logic ov_trip;      // Third consecutive over-voltage sample.
  logic latch_now;    // Any latch-type fault this cycle.
  logic auto_now;     // Any auto-recovery fault this cycle.
  logic switching;    // Next state allows gate pulses.

  assign pwm_fall = pwm_prev_q & ~s[IN_PWM];
  assign smp_now  = smp_busy_q && (smp_cnt_q == 9'(OV_DELAY_CYC - 1));
  assign ov_trip  = smp_now && ov && (ov_cnt_q == OV_FAULT_COUNT - 2'h1);
  assign latch_now = ov_trip | s[IN_SUP_OV];
  // The debounce needs the condition to outlast the interval; floating pins do not wait.
  assign auto_now  = (auto_cond && (deb_cnt_q >= DEBOUNCE_CYC)) | s[IN_FLOAT];
  assign switching = (state_d == ST_SOFT) || (state_d == ST_RUN);

  // ----------------------------------------------------------------------
  // Sequencer state machine.
  // ----------------------------------------------------------------------
  // Latch faults are tested first in every state, so they win over everything.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_STARTUP: begin
        if (latch_now) begin
          state_d = ST_LATCHED;
        end else if (s[IN_SUP_ON]) begin
          state_d = ST_SOFT;
        end
      end
      ST_SOFT, ST_RUN: begin
        if (latch_now) begin
          state_d = ST_LATCHED;
        end else if (auto_now) begin
          state_d = ST_AUTO_OFF;
        end else if (lockout) begin
          state_d = ST_STARTUP;
        end else if (state_q == ST_SOFT && CS_LIMIT_LEVEL == SS_LEVEL_MAX) begin
          state_d = ST_RUN;
        end
      end
      ST_AUTO_OFF: begin
        if (latch_now) begin
          state_d = ST_LATCHED;
        end else if (lockout) begin
          state_d = ST_STARTUP;
        end
      end
      ST_LATCHED: begin
        state_d = ST_LATCHED;
      end
      default: begin
        state_d = ST_LATCHED; // An illegal code is treated as the safe stop.
      end
    endcase
  end

  // Only the asynchronous power-down reset leaves the latched state.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= ST_STARTUP;
    end else if (CE) begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------------
  // Plateau sampling after turn-off.
  // ----------------------------------------------------------------------
  // A new turn-off restarts the delay; ringing before the delay is never sampled.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pwm_prev_q <= 1'b0;
      smp_busy_q <= 1'b0;
      smp_cnt_q  <= 9'h0;
    end else if (CE) begin
      pwm_prev_q <= s[IN_PWM];
      if (pwm_fall) begin
        smp_busy_q <= 1'b1;
        smp_cnt_q  <= 9'h0;
      end else if (smp_now) begin
        smp_busy_q <= 1'b0;
      end else if (smp_busy_q) begin
        smp_cnt_q <= smp_cnt_q + 9'h1;
      end
    end
  end

  // Consecutive over-voltage counter; cleared outside switching.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ov_cnt_q <= 2'h0;
    end else if (CE) begin
      if (!switching) begin
        ov_cnt_q <= 2'h0;
      end else if (smp_now) begin
        if (!ov || ov_trip) begin
          ov_cnt_q <= 2'h0;
        end else begin
          ov_cnt_q <= ov_cnt_q + 2'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Auto-recovery debounce.
  // ----------------------------------------------------------------------
  // Any gap in the condition restarts the count, so only a continuous fault trips.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      deb_cnt_q <= 32'h0;
    end else if (CE) begin
      if (!auto_cond || !switching) begin
        deb_cnt_q <= 32'h0;
      end else begin
        deb_cnt_q <= fps_inc(deb_cnt_q);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Soft-start ramp of the current limit.
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ss_tick_q      <= 32'h0;
      CS_LIMIT_LEVEL <= 8'h0;
    end else if (CE) begin
      if (state_d != ST_SOFT && state_d != ST_RUN) begin
        ss_tick_q      <= 32'h0;
        CS_LIMIT_LEVEL <= 8'h0;
      end else if (state_q == ST_SOFT && CS_LIMIT_LEVEL != SS_LEVEL_MAX) begin
        if (ss_tick_q >= SS_STEP_CYC - 1) begin
          ss_tick_q      <= 32'h0;
          CS_LIMIT_LEVEL <= CS_LIMIT_LEVEL + 8'h1;
        end else begin
          ss_tick_q <= fps_inc(ss_tick_q);
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Gate, burst, valley and supply charging outputs.
  // ----------------------------------------------------------------------
  // The gate uses the next state, so a fault removes it on the very edge it is seen.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      GATE_EN     <= 1'b0;
      burst_q     <= 1'b0;
      VALLEY_LOCK <= 4'h0;
    end else if (CE) begin
      GATE_EN     <= switching && !fb_low && ctrl_en_q;
      burst_q     <= switching && fb_low;
      VALLEY_LOCK <= fb_low ? VALLEY_BURST : VALLEY_REQ;
    end
  end

  // Startup current while recharging; hysteretic charging while latched.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      HV_CHARGE_EN <= 1'b1;
    end else if (CE) begin
      unique case (state_d)
        ST_STARTUP: HV_CHARGE_EN <= 1'b1;
        ST_LATCHED: begin
          if (lockout) begin
            HV_CHARGE_EN <= 1'b1;
          end else if (s[IN_LATCH_H]) begin
            HV_CHARGE_EN <= 1'b0;
          end
        end
        default: HV_CHARGE_EN <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Avalon-MM slave and interrupt logic.
  // ----------------------------------------------------------------------
  logic             take;     // Request accepted on this edge.
  logic [IRQ_W-1:0] ev;       // Events raised this cycle.
  logic [IRQ_W-1:0] rd_clr;   // Bits returned by a read of the status.
  logic [IRQ_W-1:0] stat_d;   // Next sticky status.
  logic [31:0]      rd_mux;   // Read data selected by address.

  assign take   = (AVS_READ || AVS_WRITE) && !wait_q;
  assign ev[IRQ_LATCH]   = (state_d == ST_LATCHED) && (state_q != ST_LATCHED);
  assign ev[IRQ_AUTO]    = (state_d == ST_AUTO_OFF) && (state_q != ST_AUTO_OFF);
  assign ev[IRQ_BURST]   = switching && fb_low && !burst_q;
  assign ev[IRQ_RESTART] = (state_d == ST_SOFT) && (state_q != ST_SOFT);
  // Only the bits that went out on the bus are cleared, and a new event still wins.
  assign rd_clr = (take && AVS_READ && AVS_ADDRESS == REG_IRQ_STAT) ?
                  AVS_READDATA[IRQ_W-1:0] : '0;
  assign stat_d = (irq_stat_q & ~rd_clr) | ev;

  always_comb begin
    rd_mux = 32'h0;
    unique case (AVS_ADDRESS)
      REG_CTRL:     rd_mux[0] = ctrl_en_q;
      REG_STATUS: begin
        rd_mux[ST_STATE_LSB +: 3] = state_q;
        rd_mux[ST_GATE]           = GATE_EN;
        rd_mux[ST_HV]             = HV_CHARGE_EN;
        rd_mux[ST_BURST]          = burst_q;
        rd_mux[ST_OVCNT_LSB +: 2] = ov_cnt_q;
        rd_mux[ST_LEVEL_LSB +: 8] = CS_LIMIT_LEVEL;
      end
      REG_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_q;
      REG_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_q;
      default:      rd_mux = 32'h0;
    endcase
  end

  // One wait state: data is captured in the first cycle and stands in the second.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wait_q          <= 1'b1;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h0;
    end else if (CE) begin
      wait_q          <= !((AVS_READ || AVS_WRITE) && wait_q);
      AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && wait_q);
      if (AVS_READ && wait_q) begin
        AVS_READDATA <= rd_mux;
      end
    end
  end

  // Register writes land on the accepting edge; unmapped writes are dropped.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_en_q  <= CTRL_RESET;
      irq_mask_q <= IRQ_MASK_RESET;
    end else if (CE && take && AVS_WRITE) begin
      if (AVS_ADDRESS == REG_CTRL) begin
        ctrl_en_q <= AVS_WRITEDATA[0];
      end
      if (AVS_ADDRESS == REG_IRQ_MASK) begin
        irq_mask_q <= AVS_WRITEDATA[IRQ_W-1:0];
      end
    end
  end

  // Sticky status and the level interrupt, both from flops.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_stat_q <= '0;
      IRQ        <= 1'b0;
    end else if (CE) begin
      irq_stat_q <= stat_d;
      IRQ        <= |(stat_d & irq_mask_q);
    end
  end

  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  property p_burst_off;
    @(posedge CLK) disable iff (!RST_N) (CE && fb_low) |=> !GATE_EN;
  endproperty
  a_burst_off: assert property (p_burst_off) else $error("gate pulse during burst off");

  property p_burst_on;
    @(posedge CLK) disable iff (!RST_N)
      (CE && !fb_low && ctrl_en_q && state_q == ST_RUN && state_d == ST_RUN) |=> GATE_EN;
  endproperty
  a_burst_on: assert property (p_burst_on) else $error("switching not resumed");

  property p_sample_delay;
    @(posedge CLK) disable iff (!RST_N)
      (CE && pwm_fall) ##1 (CE && !pwm_fall) [*8] |-> !smp_now;
  endproperty
  a_sample_delay: assert property (p_sample_delay) else $error("plateau sampled early");

  property p_ov_count;
    @(posedge CLK) disable iff (!RST_N)
      (CE && switching && smp_now && ov && ov_cnt_q < 2'h2) |=> ov_cnt_q == $past(ov_cnt_q) + 2'h1;
  endproperty
  a_ov_count: assert property (p_ov_count) else $error("over-voltage count not advanced");

  property p_ov_latch;
    @(posedge CLK) disable iff (!RST_N)
      (CE && ov_trip && state_q != ST_LATCHED) |=> (state_q == ST_LATCHED && !GATE_EN);
  endproperty
  a_ov_latch: assert property (p_ov_latch) else $error("third over-voltage did not latch");

  property p_ov_clear;
    @(posedge CLK) disable iff (!RST_N) (CE && smp_now && !ov) |=> ov_cnt_q == 2'h0;
  endproperty
  a_ov_clear: assert property (p_ov_clear) else $error("over-voltage count not cleared");

  property p_latch_charge;
    @(posedge CLK) disable iff (!RST_N)
      (CE && state_q == ST_LATCHED && lockout) |=> HV_CHARGE_EN;
  endproperty
  a_latch_charge: assert property (p_latch_charge) else $error("latched supply not charged");

  property p_latch_hold;
    @(posedge CLK) disable iff (!RST_N) (state_q == ST_LATCHED) |=> (state_q == ST_LATCHED);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched state released");

  property p_auto_stop;
    @(posedge CLK) disable iff (!RST_N)
      (CE && state_q == ST_RUN && auto_now && !latch_now) |=> (state_q == ST_AUTO_OFF && !GATE_EN);
  endproperty
  a_auto_stop: assert property (p_auto_stop) else $error("auto fault did not stop gate");

  property p_auto_restart;
    @(posedge CLK) disable iff (!RST_N)
      (CE && state_q == ST_AUTO_OFF && lockout && !latch_now) |=> state_q == ST_STARTUP;
  endproperty
  a_auto_restart: assert property (p_auto_restart) else $error("no restart at lockout");

endmodule : fps_sequencer

// ===== bench/fps_plant.sv
`timescale 1ns/1ps
// Power stage stand-in: 50-cycle pulses every 350 cycles while the gate is enabled.
module fps_plant (
  input  wire logic CLK,
  input  wire logic GATE_EN,
  output logic      PWM_ON
);
  logic [8:0] cnt_q = 9'h000; // Position in the switching period.
  // The pulse drops at once when the gate is withdrawn, as a real switch would.
  always_ff @(posedge CLK) begin
    cnt_q  <= (cnt_q == 9'h15d || !GATE_EN) ? 9'h000 : cnt_q + 9'h001;
    PWM_ON <= GATE_EN && cnt_q < 9'h032;
  end
endmodule : fps_plant

// ===== bench/tb.sv
`timescale 1ns/1ps
module tb
  import fps_pkg::*;
;
  logic CLK = 1'b0, RST_N = 1'b0, fb = 1'b0, ov = 1'b0, on = 1'b0, lko = 1'b0, lhi = 1'b0;
  logic sov = 1'b0, ovl = 1'b0, flt = 1'b0, rd = 1'b0, wr = 1'b0, wrq, gate, hv, irq, pwm;
  logic [3:0]  adr = 4'h0, vl;
  logic [2:0]  oth = 3'h0;
  logic        ce = 1'b1;
  logic [7:0]  lvl;
  logic [31:0] wd = 32'h0, rq, rdat;
  int          failures = 0, num_checks = 0, i;
  always #5 CLK = ~CLK;
  fps_sequencer #(.DEBOUNCE_CYC(20), .SS_STEP_CYC(2)) dut_u (.CLK(CLK), .RST_N(RST_N),
    .CE(ce), .FB_BELOW_MIN(fb), .OV_CMP(ov), .PWM_ON(pwm), .SUPPLY_ON(on),
    .SUPPLY_LOCKOUT(lko), .SUPPLY_LATCH_HIGH(lhi), .SUPPLY_OV(sov), .OVERLOAD(ovl),
    .OVERCURRENT(oth[0]), .OVERPOWER(oth[1]), .OPEN_LOOP(oth[2]), .PIN_FLOAT(flt),
    .VALLEY_REQ(4'h3), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd), .AVS_READDATA(rq), .AVS_WAITREQUEST(wrq), .GATE_EN(gate),
    .HV_CHARGE_EN(hv), .CS_LIMIT_LEVEL(lvl), .VALLEY_LOCK(vl), .IRQ(irq));
  fps_plant plant_u (.CLK(CLK), .GATE_EN(gate), .PWM_ON(pwm));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask : cyc
  // One Avalon access; the request stands until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK);
    rd  <= !w;
    wr  <= w;
    adr <= a;
    wd  <= d;
    do @(posedge CLK); while (wrq !== 1'b0);
    rdat = rq;
    rd  <= 1'b0;
    wr  <= 1'b0;
  endtask : bus
  // Waits for n turn-offs plus time for each plateau sample to land.
  task automatic fall(input int n);
    repeat (n) @(negedge pwm);
    cyc(270);
  endtask : fall
  // Supply drops to lockout, then recharges past turn-on and soft-starts.
  task automatic restart;
    on  <= 1'b0;
    lko <= 1'b1;
    cyc(5);
    lko <= 1'b0;
    on  <= 1'b1;
    cyc(700);
  endtask : restart
  task automatic complete_run;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  initial begin
    #200000;
    failures++;
    complete_run;
  end
  initial begin
    cyc(20);
    RST_N <= 1'b1;
    chk("gate", gate, 1'b0);
    chk("hv", hv, 1'b1);
    bus(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", rdat, 32'h1);
    bus(1'b0, 4'h1, 32'h0);
    chk("unmapped", rdat, 32'h0);
    bus(1'b1, REG_IRQ_MASK, 32'h2);
    on <= 1'b1;
    for (i = 0; i < 2000 && lvl !== SS_LEVEL_MAX; i++) cyc(1);
    cyc(4);
    chk("level", lvl, SS_LEVEL_MAX);
    chk("gate", gate, 1'b1);
    ce <= 1'b0;
    fb <= 1'b1;
    cyc(5);
    chk("gate", gate, 1'b1);
    ce <= 1'b1;
    cyc(5);
    chk("gate", gate, 1'b0);
    chk("valley", vl, VALLEY_BURST);
    fb <= 1'b0;
    cyc(5);
    chk("gate", gate, 1'b1);
    chk("valley", vl, 4'h3);
    bus(1'b1, REG_CTRL, 32'h0);
    cyc(2);
    chk("gate", gate, 1'b0);
    bus(1'b1, REG_CTRL, 32'h1);
    cyc(2);
    chk("gate", gate, 1'b1);
    chk("irq", irq, 1'b0);
    ovl <= 1'b1;
    cyc(10);
    chk("gate", gate, 1'b1);
    cyc(30);
    chk("gate", gate, 1'b0);
    chk("hv", hv, 1'b0);
    chk("irq", irq, 1'b1);
    bus(1'b0, REG_IRQ_STAT, 32'h0);
    cyc(2);
    chk("irq", irq, 1'b0);
    restart;
    bus(1'b0, REG_IRQ_STAT, 32'h0);
    chk("irqstat", rdat[3:0], 4'ha);
    chk("gate", gate, 1'b0);
    ovl <= 1'b0;
    restart;
    chk("gate", gate, 1'b1);
    flt <= 1'b1;
    cyc(5);
    chk("gate", gate, 1'b0);
    flt <= 1'b0;
    restart;
    // Each of the other auto-recovery conditions must debounce and stop the gate.
    for (i = 0; i < 3; i++) begin
      oth <= 3'h1 << i;
      cyc(10);
      chk("gate", gate, 1'b1);
      cyc(30);
      chk("gate", gate, 1'b0);
      oth <= 3'h0;
      restart;
    end
    fall(1);
    ov <= 1'b1;
    fall(2);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("ovcount", rdat[7:6], 2'h2);
    ov <= 1'b0;
    fall(1);
    chk("gate", gate, 1'b1);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("ovcount", rdat[7:6], 2'h0);
    ov <= 1'b1;
    fall(3);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("state", rdat[2:0], ST_LATCHED);
    lko <= 1'b1;
    cyc(5);
    chk("hv", hv, 1'b1);
    lko <= 1'b0;
    cyc(5);
    chk("hv", hv, 1'b1);
    lhi <= 1'b1;
    cyc(5);
    chk("hv", hv, 1'b0);
    lhi <= 1'b0;
    restart;
    chk("gate", gate, 1'b0);
    ov <= 1'b0;
    RST_N <= 1'b0;
    cyc(2);
    RST_N <= 1'b1;
    restart;
    chk("gate", gate, 1'b1);
    sov <= 1'b1;
    ovl <= 1'b1;
    fb <= 1'b1;
    cyc(5);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("state", rdat[2:0], ST_LATCHED);
    complete_run;
  end
endmodule : tb
